// >>> verif/fieldbus_measure_block_packer_tb.sv
// self-checking bench for the measuring block packer
// assumes the instrument bus model on the far side
`timescale 1ns/1ps
`default_nettype none
module fieldbus_measure_block_packer_tb;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, fb_init = 0, fb_assign = 0;
  logic fb_connected = 0, lap = 0, pready, pslverr, e, meas_req, meas_done, meas_present;
  logic [7:0] paddr = 0, fb_block_size = 0, fb_byte_idx = 0, fb_byte;
  logic [6:0] fb_assign_addr = 0, station_addr, sa;
  logic [31:0] pwdata = 0, prdata, r;
  logic [15:0] salt = 0;
  logic meas_ok, irq, data_exchange, bus_fault_led;
  logic [5:0] meas_addr;
  logic [3:0] meas_err;
  logic [2:0] meas_dec;
  logic [23:0] meas_value;
  int fails = 0, check_count = 0, n, s, k;
  int sz[4] = '{245, 19, 244, 1};
  always #12.5 clk = ~clk;
  fieldbus_measure_block_packer fieldbus_measure_block_packer_i (.*);
  instr_bus_model instr_bus_model_i (.*);
  always @(posedge clk) begin
    if (meas_req && (meas_addr == 0 || meas_addr > n)) begin
      fails++;
      $display("[ERR] meas_addr exp 1..%0d got %0d", n, meas_addr);
    end
    lap <= rst ? 1'b0 : lap | (meas_done && meas_addr == n);
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    check_count++;
    if (y !== x) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, x, y);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      $display("[ERR] pready exp 1 got %b", pready);
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  function automatic logic [7:0] eb(int i);
    logic [5:0] a;
    logic [31:0] v;
    a = 6'(i / 4 + 1);
    v = {a % 5 != 0, a % 5 != 0 ? 4'h0 : a[3:0], a[2:0], salt, 2'h0, a};
    if (a % 3 == 0) v = {5'h0, a[2:0], 24'h0};
    return i >= 4 * n ? 8'h00 : v[31 - 8 * (i % 4) -: 8];
  endfunction : eb
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    #1000000;
    fails++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hBB72));
    salt = 16'($urandom);
    foreach (sz[j]) begin
      s = j == 3 ? $urandom_range(244, 1) : sz[j];
      {rst, fb_init, fb_connected} <= 3'h4;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      n = s / 4;
      chk("led", 1, bus_fault_led);
      chk("station", 7'h7E, station_addr);
      {fb_block_size, fb_init} <= {8'(s), 1'b1};
      repeat (3) @(posedge clk);
      chk("exch", s < 245, data_exchange);
      if (s < 245) begin
        apb(0, 8'h08, 0);
        chk("block", {n[5:0], 8'(s)}, r);
        for (k = 0; k < 4000 && !lap; k++) @(posedge clk);
        chk("lap", n > 0, lap);
        for (int i = 0; i <= s; i++) begin
          fb_byte_idx <= 8'(i);
          repeat (2) @(posedge clk);
          chk("byte", eb(i), fb_byte);
        end
      end
      if (j == 1) begin
        apb(1, 8'h14, 1);
        repeat (2) @(posedge clk);
        chk("irq", 1, irq);
        apb(0, 8'h10, 0);
        chk("istat", 1, r[0]);
        repeat (2) @(posedge clk);
        chk("irq", 0, irq);
        apb(0, 8'h18, 0);
        chk("slverr", 1, e);
        sa = 7'($urandom_range(125, 1));
        for (int t = 0; t < 2; t++) begin
          {fb_assign, fb_assign_addr} <= {1'b1, t == 0 ? sa : ~sa};
          @(posedge clk);
          fb_assign <= 1'b0;
          repeat (2) @(posedge clk);
          chk("station", sa, station_addr);
        end
        fb_connected <= 1'b1;
        repeat (3) @(posedge clk);
        chk("led", 0, bus_fault_led);
        apb(0, 8'h04, 0);
        chk("conn", 1, r[3]);
      end
    end
    give_verdict();
  end
endmodule : fieldbus_measure_block_packer_tb
`default_nettype wire

// >>> verif/instr_bus_model.sv
// instrument bus model answering measurement requests
// assumes one request at a time; answers tied to the address
`timescale 1ns/1ps
`default_nettype none
module instr_bus_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        meas_req,
  input  wire logic [5:0]  meas_addr,
  input  wire logic [15:0] salt,
  output logic             meas_done,
  output logic             meas_present,
  output logic             meas_ok,
  output logic      [3:0]  meas_err,
  output logic      [2:0]  meas_dec,
  output logic      [23:0] meas_value
);
  logic [5:0] a_q;
  logic [1:0] w_q;
  logic       busy_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {meas_done, meas_present, meas_ok, meas_err, meas_dec, meas_value} <= '0;
      {a_q, w_q, busy_q} <= '0;
    end else begin
      meas_done <= 1'b0;
      // answer lines scramble outside the answer cycle
      {meas_present, meas_ok, meas_err, meas_dec, meas_value} <=
        ~{meas_present, meas_ok, meas_err, meas_dec, meas_value};
      if (meas_req) begin
        a_q <= meas_addr;
        w_q <= 2'($urandom_range(3, 0));
        busy_q <= 1'b1;
      end else if (busy_q && w_q != 2'h0) begin
        w_q <= w_q - 2'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        meas_done <= 1'b1;
        meas_present <= a_q % 3 != 0;
        meas_ok <= a_q % 5 != 0;
        meas_err <= a_q[3:0];
        meas_dec <= a_q[2:0];
        meas_value <= {salt, 2'h0, a_q};
      end
    end
  end
endmodule : instr_bus_model
`default_nettype wire

// >>> verif/packer_props.sv
// port checker for the measuring block packer
// assumes one clock, reset high; bound to the packer below
`timescale 1ns/1ps
`default_nettype none
module packer_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       fb_init,
  input wire logic       fb_assign,
  input wire logic [6:0] fb_assign_addr,
  input wire logic       fb_connected,
  input wire logic [7:0] fb_byte,
  input wire logic [6:0] station_addr,
  input wire logic       data_exchange,
  input wire logic       bus_fault_led,
  input wire logic       meas_req,
  input wire logic [5:0] meas_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_hold_exch: assert property (!data_exchange |-> !meas_req && fb_byte == 8'h00)
    else $error("exchange before init");
  a_exch_cause: assert property ($rose(data_exchange) |-> $past(fb_init) || $past(fb_init, 2))
    else $error("exchange without init");
  a_addr_range: assert property (meas_req |-> meas_addr >= 6'h01 && meas_addr <= 6'h3D)
    else $error("address out of range");
  a_req_pulse: assert property (meas_req |=> !meas_req)
    else $error("request held");
  a_led_hold: assert property (bus_fault_led && !fb_connected |=> bus_fault_led)
    else $error("led off early");
  a_led_off: assert property (fb_connected |-> ##[1:2] !bus_fault_led)
    else $error("led stays on");
  a_station_take: assert property (fb_assign && station_addr == 7'h7E |=>
    station_addr == $past(fb_assign_addr)) else $error("station not taken");
  a_station_keep: assert property (fb_assign && station_addr != 7'h7E && !psel |=>
    $stable(station_addr)) else $error("station overwritten");
endmodule : packer_props
bind fieldbus_measure_block_packer packer_props packer_props_i (.*);
`default_nettype wire

// >>> verilog/fieldbus_measure_block_packer.sv
// measuring-value block packer: APB slave, instrument bus poller, block buffer
// assumes synchronous instrument answers and master-side byte read port
//
// Function
// - hold exchange until master assigns block size
// - input count is block size over four
// - block at most 244 bytes, 61 inputs
// - poll selected inputs repeatedly, ignore higher addresses
// - leftover block bytes read as zero
// - absent input still yields record, marked invalid
// - status bit 7 set means value valid
// - status bits 6..3 carry error code
// - status bits 2..0 give decimal digits
// - bytes two to four: value, high first
// - station 126 accepts master-assigned address
// - fault indicator on until connection established
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "packer_consts.svh"
module fieldbus_measure_block_packer #(
  parameter int MAX_INPUTS = `MAX_INPUTS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fb_init,
  input  wire logic [7:0]  fb_block_size,
  input  wire logic        fb_assign,
  input  wire logic [6:0]  fb_assign_addr,
  input  wire logic        fb_connected,
  input  wire logic [7:0]  fb_byte_idx,
  output logic      [7:0]  fb_byte,
  output logic      [6:0]  station_addr,
  output logic             data_exchange,
  output logic             bus_fault_led,
  output logic             meas_req,
  output logic      [5:0]  meas_addr,
  input  wire logic        meas_done,
  input  wire logic        meas_present,
  input  wire logic        meas_ok,
  input  wire logic [3:0]  meas_err,
  input  wire logic [2:0]  meas_dec,
  input  wire logic [23:0] meas_value,
  output logic             irq
);
  import packer_pkg::*;

  function automatic logic [7:0] make_status(input logic ok, input logic [3:0] err,
                                             input logic [2:0] dec);
    make_status = ok ? {1'b1, 4'h0, dec} : {1'b0, err, dec};
  endfunction : make_status

  function automatic logic [5:0] step_idx(input logic [5:0] cur, input logic last);
    step_idx = last ? 6'd0 : cur + 6'd1;
  endfunction : step_idx

  function automatic logic [7:0] pick_byte(input logic [31:0] rec, input logic [1:0] sel);
    case (sel)
      2'd0:    pick_byte = rec[31:24];
      2'd1:    pick_byte = rec[23:16];
      2'd2:    pick_byte = rec[15:8];
      default: pick_byte = rec[7:0];
    endcase
  endfunction : pick_byte

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `OFF_CTRL, `OFF_STATUS, `OFF_BLOCK,
      `OFF_STATION, `OFF_IRQ_STAT, `OFF_IRQ_MASK: is_mapped = 1'b1;
      default:                                    is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  logic [31:0]  rec_q [MAX_INPUTS];
  scan_state_t  state_q, state_d;
  logic [7:0]   block_q;
  logic [5:0]   count_q;
  logic [5:0]   idx_q;
  logic [6:0]   station_q;
  logic         init_q;
  logic         conn_q;
  logic         en_q;
  logic [2:0]   irq_stat_q;
  logic [2:0]   irq_mask_q;
  logic [31:0]  rdata_q;
  logic         ready_q;
  logic [7:0]   fb_byte_q;
  logic         req_q;
  logic [5:0]   addr_q;

  wire        setup_ph   = psel & ~penable;
  wire        access_ph  = psel & penable & ready_q;
  wire        wr_ctrl    = access_ph & pwrite & (paddr == `OFF_CTRL);
  wire        wr_mask    = access_ph & pwrite & (paddr == `OFF_IRQ_MASK);
  wire        wr_station = access_ph & pwrite & (paddr == `OFF_STATION);
  wire        rd_istat   = access_ph & ~pwrite & (paddr == `OFF_IRQ_STAT);
  wire        mapped     = is_mapped(paddr);
  wire        size_ok    = (fb_block_size != 8'h00) &&
                           (fb_block_size <= 8'(`MAX_BLOCK_BYTES));
  wire        init_ev    = fb_init & size_ok & ~init_q;
  wire        cycle_ev   = (state_q == ST_WRITE) && (idx_q == count_q - 6'd1);
  wire        conn_ev    = fb_connected & ~conn_q;
  wire [2:0]  ev         = {conn_ev, cycle_ev, init_ev};
  wire [31:0] new_rec    = {make_status(meas_ok & meas_present, meas_present ? meas_err : 4'h0,
                                        meas_dec),
                            meas_present ? meas_value : 24'h000000};
  wire [5:0]  rec_sel    = fb_byte_idx[7:2];
  wire [1:0]  byte_sel   = fb_byte_idx[1:0];
  wire        in_rec     = (rec_sel < count_q);
  wire [5:0]  rec_rd     = in_rec ? rec_sel : 6'd0;
  wire [31:0] sel_rec    = rec_q[rec_rd];
  wire [7:0]  sel_byte   = pick_byte(sel_rec, byte_sel);
  wire [7:0]  byte_out   = (init_q && in_rec) ? sel_byte : 8'h00;

  // poll loop: request, wait, store
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_WAIT_INIT: begin
        if (init_q && en_q && count_q != 6'd0) state_d = ST_REQ;
      end
      ST_REQ: begin
        state_d = ST_WAIT_VAL;
      end
      ST_WAIT_VAL: begin
        if (meas_done) state_d = ST_WRITE;
      end
      ST_WRITE: begin
        state_d = ST_REQ;
      end
      default: begin
        state_d = ST_WAIT_INIT;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_WAIT_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
    end else begin
      req_q <= (state_d == ST_REQ);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_q <= 6'd0;
    end else if (state_q == ST_WRITE) begin
      idx_q <= step_idx(idx_q, cycle_ev);
    end
  end

  // bus address tracks idx plus one from its own flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= 6'd1;
    end else if (state_q == ST_WRITE) begin
      addr_q <= step_idx(idx_q, cycle_ev) + 6'd1;
    end
  end

  // records replaced whole at the answer edge
  always_ff @(posedge clk) begin
    if (state_q == ST_WAIT_VAL && meas_done) begin
      rec_q[idx_q] <= new_rec;
    end
  end

  // block size latched once per reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      block_q <= 8'h00;
    end else if (init_ev) begin
      block_q <= fb_block_size;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= 6'd0;
    end else if (init_ev) begin
      count_q <= fb_block_size[7:2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_q <= 1'b0;
    end else if (init_ev) begin
      init_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      station_q <= `RST_STATION;
    end else if (wr_station) begin
      station_q <= pwdata[6:0];
    end else if (fb_assign && station_q == `FREE_STATION) begin
      station_q <= fb_assign_addr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conn_q <= 1'b0;
    end else if (fb_connected) begin
      conn_q <= 1'b1;
    end
  end

  // scan enable, on from reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b1;
    end else if (wr_ctrl) begin
      en_q <= pwdata[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask_q <= 3'h0;
    end else if (wr_mask) begin
      irq_mask_q <= pwdata[2:0];
    end
  end

  // set beats the read-clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= 3'h0;
    end else begin
      irq_stat_q <= (rd_istat ? 3'h0 : irq_stat_q) | ev;
    end
  end

  // read-back words, captured in the setup cycle
  wire [31:0] rd_ctrl    = {31'h0, en_q};
  wire [31:0] rd_status  = {22'h0, idx_q, conn_q, init_q, state_q};
  wire [31:0] rd_block   = {18'h0, count_q, block_q};
  wire [31:0] rd_station = {25'h0, station_q};
  wire [31:0] rd_flags   = {29'h0, irq_stat_q};
  wire [31:0] rd_mask    = {29'h0, irq_mask_q};
  wire [31:0] rd_word    = (paddr == `OFF_CTRL)     ? rd_ctrl :
                           (paddr == `OFF_STATUS)   ? rd_status :
                           (paddr == `OFF_BLOCK)    ? rd_block :
                           (paddr == `OFF_STATION)  ? rd_station :
                           (paddr == `OFF_IRQ_STAT) ? rd_flags :
                           (paddr == `OFF_IRQ_MASK) ? rd_mask : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= setup_ph;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      rdata_q <= rd_word;
    end
  end

  // block read port, one cycle behind the index
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fb_byte_q <= 8'h00;
    end else begin
      fb_byte_q <= byte_out;
    end
  end

  logic irq_q;
  logic fault_q;
  logic xchg_q;

  // level from masked flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_q <= 1'b1;
    end else begin
      fault_q <= ~(conn_q | fb_connected);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xchg_q <= 1'b0;
    end else begin
      xchg_q <= init_q;
    end
  end

  // unmapped address answers with error and ready
  logic pslverr_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= setup_ph & ~mapped;
    end
  end

  assign prdata        = rdata_q;
  assign pready        = ready_q;
  assign pslverr       = pslverr_q;
  assign fb_byte       = fb_byte_q;
  assign station_addr  = station_q;
  assign data_exchange = xchg_q;
  assign bus_fault_led = fault_q;
  assign meas_req      = req_q;
  assign meas_addr     = addr_q;
  assign irq           = irq_q;
endmodule : fieldbus_measure_block_packer
`default_nettype wire

// >>> verilog/packer_consts.svh
// constants for the measuring block packer
// assumes inclusion by bare name from package and module
`ifndef PACKER_CONSTS_SVH
`define PACKER_CONSTS_SVH
`define REC_BYTES        4
`define MAX_BLOCK_BYTES  244
`define MAX_INPUTS       61
`define FREE_STATION     7'h7E
`define ST_VALID_BIT     7
`define ST_ERR_LSB       3
`define ST_DEC_LSB       0
`define OFF_CTRL         8'h00
`define OFF_STATUS       8'h04
`define OFF_BLOCK        8'h08
`define OFF_STATION      8'h0C
`define OFF_IRQ_STAT     8'h10
`define OFF_IRQ_MASK     8'h14
`define RST_STATION      7'h7E
`endif

// >>> verilog/packer_pkg.sv
// types for the measuring block packer
// assumes packer_consts.svh on the include path
`include "packer_consts.svh"
package packer_pkg;
  typedef enum logic [1:0] {
    ST_WAIT_INIT = 2'b00,
    ST_REQ       = 2'b01,
    ST_WAIT_VAL  = 2'b11,
    ST_WRITE     = 2'b10
  } scan_state_t;
  typedef logic [7:0] byte_t;
endpackage : packer_pkg
